// ===== verilog/sdac_ctrl.sv
// Conversion control and serial port of the sigma-delta converter.
`timescale 1ns/100ps
`include "sdac_cfg.svh"
module sdac_ctrl #(
  parameter int OSC_START_CYC = `SDAC_OSC_START_CYC,
  parameter logic [7:0] ID_VAL = 8'h5a // Arbitrary identity value.
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  output logic dout_rdy_n_o,
  output logic dout_rdy_oe,
  input wire logic res_valid,
  input wire logic [`SDAC_W-1:0] res_data,
  output logic res_ready,
  output logic mod_run,
  output logic buf_en,
  output sdac_pkg::sdac_filt_t filter_sel,
  output logic [3:0] rate_code,
  output logic rdy_n
);
  import sdac_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Word length in bits for a register select code.
  function automatic logic [4:0] reg_len(input logic [2:0] rs);
    unique case (rs)
      `SDAC_RS_MODE, `SDAC_RS_CFG: reg_len = 5'd16;
      `SDAC_RS_DATA, `SDAC_RS_OFS, `SDAC_RS_FS: reg_len = 5'd24;
      default: reg_len = 5'd8;
    endcase
  endfunction

  // Filter family from the update rate code.
  function automatic sdac_filt_t filt_of(input logic [3:0] r);
    if (r <= `SDAC_RATE_INT_MAX) begin
      filt_of = SDAC_FILT_INTEG;
    end else if (r <= `SDAC_RATE_S4_MAX) begin
      filt_of = SDAC_FILT_SINC4;
    end else if (r <= `SDAC_RATE_MS3_MAX) begin
      filt_of = SDAC_FILT_MSINC3;
    end else begin
      filt_of = SDAC_FILT_SINC3_AVG;
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic sclk_q1, sclk_q2, sclk_q3;
  logic cs_q1, cs_q2, cs_q3;
  logic din_q1, din_q2;
  logic rise, fall, cs_low, cs_fall;
  logic [5:0] ones_reg;
  logic soft_rst_reg;
  sdac_st_t st_reg;
  logic [4:0] cnt_reg;
  logic [23:0] in_sh_reg;
  logic [2:0] rs_reg;
  logic [7:0] cmd_byte;
  logic [23:0] word_in;
  logic cmd_done, wr_done, rd_done, cread_reg;
  logic [15:0] mode_reg, cfg_reg;
  logic [7:0] io_reg;
  logic [23:0] ofs_reg, fs_reg, data_reg, rd_word, out_sh_reg;
  logic out_act_reg, dout_bit_reg, shifting;
  logic run_reg, single_reg, osc_wait_reg, disc_reg;
  logic [31:0] osc_cnt_reg;
  logic upd_reg, keep_reg, cread_busy_reg, cread_load;
  logic [4:0] ocnt_reg;
  logic fifo_valid, pop_ok;
  logic [`SDAC_W-1:0] fifo_data;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  // Three flops on the clock and select pins, two on data; edges are taken from the second and third only.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q1 <= 1'b1;
      sclk_q2 <= 1'b1;
      sclk_q3 <= 1'b1;
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      din_q1 <= 1'b0;
      din_q2 <= 1'b0;
    end else begin
      sclk_q1 <= sclk_pin;
      sclk_q2 <= sclk_q1;
      sclk_q3 <= sclk_q2;
      cs_q1 <= cs_n_pin;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      din_q1 <= din_pin;
      din_q2 <= din_q1;
    end
  end

  assign cs_low = !cs_q2;
  assign cs_fall = !cs_q2 && cs_q3;
  assign rise = cs_low && sclk_q2 && !sclk_q3;
  assign fall = cs_low && !sclk_q2 && sclk_q3;
  assign cmd_byte = {in_sh_reg[6:0], din_q2};
  assign word_in = {in_sh_reg[22:0], din_q2};
  assign cmd_done = rise && st_reg == SDAC_ST_CMD && cnt_reg == 5'd7;
  assign wr_done = rise && st_reg == SDAC_ST_WR && cnt_reg == reg_len(rs_reg) - 5'd1;
  assign rd_done = rise && st_reg == SDAC_ST_RD && cnt_reg == reg_len(rs_reg) - 5'd1;

  // ****************************************************************
  // Interface reset by a run of ones
  // ****************************************************************
  // The count saturates so one long run gives a single reset pulse.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_reg <= '0;
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= 1'b0;
      if (rise) begin
        if (!din_q2) begin
          ones_reg <= '0;
        end else if (ones_reg != `SDAC_RST_ONES) begin
          ones_reg <= ones_reg + 6'h01;
          soft_rst_reg <= (ones_reg == `SDAC_RST_ONES - 6'h01);
        end
      end
    end
  end

  // ****************************************************************
  // Serial sequencer
  // ****************************************************************
  // A raised chip select abandons any word half shifted in.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= SDAC_ST_CMD;
      cnt_reg <= '0;
      in_sh_reg <= '0;
      rs_reg <= `SDAC_RS_COMM;
      cread_reg <= 1'b0;
    end else if (soft_rst_reg || !cs_low) begin
      st_reg <= SDAC_ST_CMD;
      cnt_reg <= '0;
      if (soft_rst_reg) cread_reg <= 1'b0;
    end else if (rise) begin
      in_sh_reg <= word_in;
      cnt_reg <= cnt_reg + 5'd1;
      if (cmd_done) begin
        cnt_reg <= '0;
        if (cread_reg) begin
          // Only the exit command is heard while streaming.
          if (cmd_byte == `SDAC_CMD_CREAD_OFF && !rdy_n) cread_reg <= 1'b0;
        end else if (cmd_byte == `SDAC_CMD_CREAD_ON) begin
          cread_reg <= 1'b1;
        end else if (!cmd_byte[`SDAC_C_WEN]) begin
          rs_reg <= cmd_byte[`SDAC_C_RS_HI:`SDAC_C_RS_LO];
          st_reg <= cmd_byte[`SDAC_C_RW] ? SDAC_ST_RD : SDAC_ST_WR;
        end
      end else if (wr_done || rd_done) begin
        st_reg <= SDAC_ST_CMD;
        cnt_reg <= '0;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Writes to read-only selects are shifted in and dropped.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= `SDAC_CFG_RST;
      io_reg <= `SDAC_IO_RST;
      ofs_reg <= `SDAC_OFS_RST;
      fs_reg <= `SDAC_FS_RST;
    end else if (soft_rst_reg) begin
      cfg_reg <= `SDAC_CFG_RST;
      io_reg <= `SDAC_IO_RST;
      ofs_reg <= `SDAC_OFS_RST;
      fs_reg <= `SDAC_FS_RST;
    end else if (wr_done) begin
      unique case (rs_reg)
        `SDAC_RS_CFG: cfg_reg <= word_in[15:0];
        `SDAC_RS_IO: io_reg <= word_in[7:0];
        `SDAC_RS_OFS: ofs_reg <= word_in;
        `SDAC_RS_FS: fs_reg <= word_in;
        default: ;
      endcase
    end
  end

  // Read value, left aligned so the first bit out is always bit 23.
  // Selected by the command byte now ending, as rs_reg only takes it at this edge.
  always_comb begin
    rd_word = '0;
    unique case (cmd_byte[`SDAC_C_RS_HI:`SDAC_C_RS_LO])
      `SDAC_RS_COMM: rd_word = {rdy_n, 23'h0};
      `SDAC_RS_MODE: rd_word = {mode_reg, 8'h00};
      `SDAC_RS_CFG: rd_word = {cfg_reg, 8'h00};
      `SDAC_RS_DATA: rd_word = data_reg;
      `SDAC_RS_ID: rd_word = {ID_VAL, 16'h0000};
      `SDAC_RS_IO: rd_word = {io_reg, 16'h0000};
      `SDAC_RS_OFS: rd_word = ofs_reg;
      `SDAC_RS_FS: rd_word = fs_reg;
    endcase
  end

  // ****************************************************************
  // Output shifter
  // ****************************************************************
  assign shifting = (st_reg == SDAC_ST_RD) || cread_busy_reg;

  // Bits change on the falling serial edge; a chip select fall in a
  // streamed word presents the first bit at once for frame-sync hosts.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sh_reg <= '0;
      out_act_reg <= 1'b0;
      dout_bit_reg <= 1'b1;
    end else if (!cs_low || soft_rst_reg) begin
      out_act_reg <= 1'b0;
    end else if (cread_load) begin
      out_sh_reg <= fifo_data;
      out_act_reg <= 1'b0;
    end else if (cmd_done && !cread_reg) begin
      // While streaming, byte boundaries must not reload the streamed word.
      out_sh_reg <= rd_word;
      out_act_reg <= 1'b0;
    end else if ((fall || (cs_fall && cread_busy_reg)) && shifting) begin
      dout_bit_reg <= out_sh_reg[23];
      out_sh_reg <= {out_sh_reg[22:0], 1'b0};
      out_act_reg <= 1'b1;
    end else if (fall) begin
      out_act_reg <= 1'b0;
    end
  end

  // Pin drive: data while shifting, else the ready level.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_rdy_n_o <= 1'b1;
      dout_rdy_oe <= 1'b0;
    end else begin
      dout_rdy_n_o <= out_act_reg ? dout_bit_reg : rdy_n;
      dout_rdy_oe <= cs_low;
    end
  end

  // ****************************************************************
  // Conversion control
  // ****************************************************************
  // The mode register lives here because a finished single
  // conversion rewrites its own mode field to power-down.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= `SDAC_MODE_RST;
      run_reg <= 1'b1;
      single_reg <= 1'b0;
      osc_wait_reg <= 1'b0;
      osc_cnt_reg <= '0;
    end else if (soft_rst_reg) begin
      mode_reg <= `SDAC_MODE_RST;
      run_reg <= 1'b1;
      single_reg <= 1'b0;
      osc_wait_reg <= 1'b0;
    end else if (wr_done && rs_reg == `SDAC_RS_MODE) begin
      mode_reg <= word_in[15:0];
      run_reg <= (word_in[`SDAC_M_MD_HI:`SDAC_M_MD_LO] == SDAC_MD_CONT);
      single_reg <= (word_in[`SDAC_M_MD_HI:`SDAC_M_MD_LO] == SDAC_MD_SINGLE);
      osc_wait_reg <= (word_in[`SDAC_M_MD_HI:`SDAC_M_MD_LO] == SDAC_MD_SINGLE);
      osc_cnt_reg <= 32'(OSC_START_CYC);
    end else if (osc_wait_reg) begin
      osc_cnt_reg <= osc_cnt_reg - 32'd1;
      if (osc_cnt_reg <= 32'd1) begin
        osc_wait_reg <= 1'b0;
        run_reg <= 1'b1;
      end
    end else if (upd_reg && keep_reg && single_reg) begin
      run_reg <= 1'b0;
      single_reg <= 1'b0;
      mode_reg[`SDAC_M_MD_HI:`SDAC_M_MD_LO] <= SDAC_MD_PDOWN;
    end
  end

  // ****************************************************************
  // Result update and ready flag
  // ****************************************************************
  // A pending normal read of the data word stalls the FIFO, so a
  // result is held rather than lost while the host is still reading.
  assign pop_ok = fifo_valid && !upd_reg && !osc_wait_reg &&
                  !(st_reg == SDAC_ST_RD && rs_reg == `SDAC_RS_DATA);
  assign cread_load = upd_reg && keep_reg && cread_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_n <= 1'b1;
      data_reg <= '0;
      upd_reg <= 1'b0;
      keep_reg <= 1'b0;
      disc_reg <= 1'b0;
      cread_busy_reg <= 1'b0;
      ocnt_reg <= '0;
    end else if (soft_rst_reg) begin
      rdy_n <= 1'b1;
      data_reg <= '0;
      upd_reg <= 1'b0;
      disc_reg <= 1'b0;
      cread_busy_reg <= 1'b0;
    end else begin
      if (wr_done && rs_reg == `SDAC_RS_MODE) disc_reg <= 1'b0;
      // Host reads end first, so a result landing now still wins.
      if (rd_done && rs_reg == `SDAC_RS_DATA) rdy_n <= 1'b1;
      if (rise && cread_busy_reg && out_act_reg) begin
        ocnt_reg <= ocnt_reg + 5'd1;
        if (ocnt_reg == 5'(`SDAC_W - 1)) begin
          cread_busy_reg <= 1'b0;
          rdy_n <= 1'b1;
        end
      end
      if (upd_reg) begin
        upd_reg <= 1'b0;
        if (keep_reg) begin
          data_reg <= fifo_data;
          rdy_n <= 1'b0;
          cread_busy_reg <= cread_reg;
          ocnt_reg <= '0;
        end
      end else if (pop_ok) begin
        upd_reg <= 1'b1;
        // The first single result only settles the filter.
        keep_reg <= run_reg && (!single_reg || disc_reg);
        if (run_reg && single_reg) disc_reg <= 1'b1;
        if (run_reg && (!single_reg || disc_reg)) rdy_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Front-end controls
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mod_run <= 1'b0;
      buf_en <= 1'b0;
      filter_sel <= SDAC_FILT_SINC3_AVG;
      rate_code <= '0;
    end else begin
      mod_run <= run_reg;
      buf_en <= mode_reg[`SDAC_M_BUF];
      filter_sel <= filt_of(mode_reg[`SDAC_M_RATE_HI:`SDAC_M_RATE_LO]);
      rate_code <= mode_reg[`SDAC_M_RATE_HI:`SDAC_M_RATE_LO];
    end
  end

  // ****************************************************************
  // Result FIFO
  // ****************************************************************
  sdac_fifo #(
    .WIDTH(`SDAC_W),
    .DEPTH(`SDAC_FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(res_valid),
    .in_data(res_data),
    .in_ready(res_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(upd_reg)
  );
endmodule // sdac_ctrl

// ===== common/sdac_cfg.svh
// Constants for the sigma-delta converter control and serial port.
`ifndef SDAC_CFG_SVH
`define SDAC_CFG_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define SDAC_CLK_HZ 25000000
`define SDAC_OSC_START_US 1000
`define SDAC_OSC_START_CYC (`SDAC_OSC_START_US * (`SDAC_CLK_HZ / 1000000))
`define SDAC_RST_ONES 6'h20
// ****************************************************************
// Data path
// ****************************************************************
`define SDAC_W 24
`define SDAC_FIFO_DEPTH 16
// ****************************************************************
// Register select codes
// ****************************************************************
`define SDAC_RS_COMM 3'h0
`define SDAC_RS_MODE 3'h1
`define SDAC_RS_CFG 3'h2
`define SDAC_RS_DATA 3'h3
`define SDAC_RS_ID 3'h4
`define SDAC_RS_IO 3'h5
`define SDAC_RS_OFS 3'h6
`define SDAC_RS_FS 3'h7
// ****************************************************************
// Fields and commands
// ****************************************************************
`define SDAC_C_WEN 7
`define SDAC_C_RW 6
`define SDAC_C_RS_HI 5
`define SDAC_C_RS_LO 3
`define SDAC_CMD_CREAD_ON 8'h5c
`define SDAC_CMD_CREAD_OFF 8'h58
`define SDAC_M_MD_HI 15
`define SDAC_M_MD_LO 13
`define SDAC_M_BUF 4
`define SDAC_M_RATE_HI 3
`define SDAC_M_RATE_LO 0
`define SDAC_RATE_INT_MAX 4'h1
`define SDAC_RATE_S4_MAX 4'h6
`define SDAC_RATE_MS3_MAX 4'ha
// ****************************************************************
// Reset values
// ****************************************************************
`define SDAC_MODE_RST 16'h001a
`define SDAC_CFG_RST 16'h0710
`define SDAC_IO_RST 8'h00
`define SDAC_OFS_RST 24'h800000
`define SDAC_FS_RST 24'h500000
`endif

// ===== common/sdac_pkg.sv
// Types shared by the converter control block.
package sdac_pkg;
  typedef enum logic [1:0] {
    SDAC_ST_CMD = 2'h0,
    SDAC_ST_WR = 2'h1,
    SDAC_ST_RD = 2'h2
  } sdac_st_t;
  typedef enum logic [2:0] {
    SDAC_MD_CONT = 3'h0,
    SDAC_MD_SINGLE = 3'h1,
    SDAC_MD_IDLE = 3'h2,
    SDAC_MD_PDOWN = 3'h3
  } sdac_md_t;
  typedef enum logic [1:0] {
    SDAC_FILT_SINC3_AVG = 2'h0,
    SDAC_FILT_MSINC3 = 2'h1,
    SDAC_FILT_SINC4 = 2'h2,
    SDAC_FILT_INTEG = 2'h3
  } sdac_filt_t;
endpackage

// ===== verilog/sdac_fifo.sv
// Result FIFO between the decimation filter and the serial port.
`timescale 1ns/100ps
module sdac_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  // Ready is registered so the filter sees it straight from a flop.
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  // Occupancy follows both sides in the same cycle.
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != (AW+1)'(DEPTH));
    end
  end

  // Storage has no reset; empty words are never read.
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end
endmodule // sdac_fifo

// ===== sim/sdac_ctrl_sva.sv
// Port-level checker for the converter control block.
`timescale 1ns/100ps
`include "sdac_cfg.svh"
module sdac_ctrl_sva (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  input wire logic dout_rdy_n_o,
  input wire logic dout_rdy_oe,
  input wire logic res_valid,
  input wire logic [`SDAC_W-1:0] res_data,
  input wire logic res_ready,
  input wire logic mod_run,
  input wire logic buf_en,
  input wire sdac_pkg::sdac_filt_t filter_sel,
  input wire logic [3:0] rate_code,
  input wire logic rdy_n
);
  import sdac_pkg::*;
  logic [3:0] age_reg;
  logic sclk_q_reg;
  logic [5:0] ones_reg;
  sdac_filt_t filt_exp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Age since reset, so the first edges never compare against reset values.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) age_reg <= 4'h0;
    else if (age_reg != 4'h8) age_reg <= age_reg + 4'h1;
  end
  // Run of ones at serial rising edges; it saturates so it cannot wrap.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q_reg <= 1'b1;
      ones_reg <= 6'h0;
    end else begin
      sclk_q_reg <= sclk_pin;
      if (cs_n_pin) ones_reg <= 6'h0;
      else if (sclk_pin && !sclk_q_reg && !din_pin) ones_reg <= 6'h0;
      else if (sclk_pin && !sclk_q_reg && ones_reg != `SDAC_RST_ONES) ones_reg <= ones_reg + 6'h1;
    end
  end
  // Filter expected for the current rate code.
  always_comb begin
    if (rate_code <= `SDAC_RATE_INT_MAX) filt_exp = SDAC_FILT_INTEG;
    else if (rate_code <= `SDAC_RATE_S4_MAX) filt_exp = SDAC_FILT_SINC4;
    else if (rate_code <= `SDAC_RATE_MS3_MAX) filt_exp = SDAC_FILT_MSINC3;
    else filt_exp = SDAC_FILT_SINC3_AVG;
  end
  sequence s_cs_low;
    !cs_n_pin [*5];
  endsequence
  sequence s_cs_high;
    cs_n_pin [*5];
  endsequence
  sequence s_sclk_quiet;
    $stable(sclk_pin) [*6];
  endsequence
  a_oe_while_sel: assert property (s_cs_low |-> dout_rdy_oe)
    else $error("line not driven while selected");
  a_oe_off_free: assert property (s_cs_high |-> !dout_rdy_oe)
    else $error("line driven while deselected");
  a_filter_by_rate: assert property (age_reg == 4'h8 |-> filter_sel == filt_exp)
    else $error("filter does not match rate");
  a_filter_with_rate: assert property (age_reg == 4'h8 && $changed(filter_sel) |-> $changed(rate_code))
    else $error("filter changed without rate");
  a_run_on_release: assert property ($rose(arst_n) |=> mod_run && rate_code == 4'ha && buf_en)
    else $error("wrong state after reset");
  a_soft_reset_mode: assert property ($rose(ones_reg == `SDAC_RST_ONES) |-> ##[1:8] (rate_code == 4'ha && buf_en))
    else $error("ones run did not reset mode");
  a_quiet_no_change: assert property ((age_reg == 4'h8 ##0 s_sclk_quiet) |-> $stable(rate_code) && $stable(buf_en))
    else $error("mode changed without serial clock");
  a_full_after_push: assert property ($fell(res_ready) |-> $past(res_valid))
    else $error("fifo full without push");
endmodule // sdac_ctrl_sva
bind sdac_ctrl sdac_ctrl_sva u_sva (.sys_clk(sys_clk), .arst_n(arst_n), .sclk_pin(sclk_pin),
  .cs_n_pin(cs_n_pin), .din_pin(din_pin), .dout_rdy_n_o(dout_rdy_n_o), .dout_rdy_oe(dout_rdy_oe),
  .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready), .mod_run(mod_run),
  .buf_en(buf_en), .filter_sel(filter_sel), .rate_code(rate_code), .rdy_n(rdy_n));

// ===== sim/sdac_host_model.sv
// Host serial port model driving the converter's serial pins.
`timescale 1ns/100ps
module sdac_host_model (
  input wire logic sys_clk,
  input wire logic dout_line,
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic din_pin
);
  // ****************************************************************
  // Serial access
  // ****************************************************************
  // Clock rests high and data low between transfers.
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b1;
    din_pin = 1'b0;
  end
  // Chip select; three-wire use keeps it low from here on.
  task automatic select();
    @(posedge sys_clk);
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Shifts n bits, first bit first; output is taken late in the high phase,
  // well clear of the device's turnaround after the falling edge.
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      sclk_pin <= 1'b0;
      din_pin <= tx[i];
      repeat (4) @(posedge sys_clk);
      sclk_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rx = {rx[30:0], dout_line};
    end
    @(posedge sys_clk);
    din_pin <= 1'b0;
  endtask
  // Command byte first, then the register word.
  task automatic access(input logic [7:0] cmd, input int n, input logic [31:0] tx,
                        output logic [31:0] rx);
    xfer(8, {24'h0, cmd}, rx);
    xfer(n, tx, rx);
  endtask
endmodule // sdac_host_model

// ===== sim/test_sdac_ctrl.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_sdac_ctrl;
  import sdac_pkg::*;
  typedef struct packed {logic [15:0] mode; sdac_filt_t filt;} sdac_row_t;
  logic sys_clk = 1'b0, arst_n = 1'b0, res_valid = 1'b0, line_last = 1'b1;
  logic sclk_pin, cs_n_pin, din_pin, dout_rdy_n_o, dout_rdy_oe, res_ready;
  logic mod_run, buf_en, rdy_n, dout_line;
  logic [23:0] res_data = 24'h0;
  logic [3:0] rate_code;
  logic [31:0] rx;
  sdac_filt_t filter_sel;
  int n_fail = 0, n_tests = 0, k;
  sdac_row_t rows [8] = '{'{16'h0001, SDAC_FILT_INTEG}, '{16'h0010, SDAC_FILT_INTEG},
    '{16'h0012, SDAC_FILT_SINC4}, '{16'h0006, SDAC_FILT_SINC4}, '{16'h0017, SDAC_FILT_MSINC3},
    '{16'h000a, SDAC_FILT_MSINC3}, '{16'h001b, SDAC_FILT_SINC3_AVG},
    '{16'h000f, SDAC_FILT_SINC3_AVG}};
  sdac_ctrl #(.OSC_START_CYC(20)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .din_pin(din_pin), .dout_rdy_n_o(dout_rdy_n_o),
    .dout_rdy_oe(dout_rdy_oe), .res_valid(res_valid), .res_data(res_data),
    .res_ready(res_ready), .mod_run(mod_run), .buf_en(buf_en), .filter_sel(filter_sel),
    .rate_code(rate_code), .rdy_n(rdy_n));
  sdac_host_model i_host (.sys_clk(sys_clk), .dout_line(dout_line), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .din_pin(din_pin));
  // Undriven line shows the inverse of its last level, so stale data never matches.
  assign dout_line = dout_rdy_oe ? dout_rdy_n_o : ~line_last;
  always @(posedge sys_clk) begin
    if (dout_rdy_oe) line_last <= dout_rdy_n_o;
  end
  // 25 MHz system clock.
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One result word from the filter side.
  task automatic push(input logic [23:0] d);
    res_valid <= 1'b1;
    res_data <= d;
    @(posedge sys_clk);
    `CHK("res_ready", 1'b1, res_ready)
    res_valid <= 1'b0;
  endtask
  // Bounded wait for a new result to be flagged.
  task automatic wait_rdy();
    for (k = 0; k < 400 && rdy_n !== 1'b0; k++) @(posedge sys_clk);
    if (k == 400) begin
      n_fail++;
      $display("wrong value rdy_n expected 0 seen %b", rdy_n);
      stop_test();
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    tick(10);
    arst_n <= 1'b1;
    tick(12);
    i_host.select();
    `CHK("mod_run", 1'b1, mod_run)
    `CHK("filter", SDAC_FILT_MSINC3, filter_sel)
    `CHK("rdy_n", 1'b1, rdy_n)
    i_host.access(8'h48, 16, 32'h0, rx);
    `CHK("mode", 16'h001a, rx[15:0])
    $display("done: reset");
    foreach (rows[i]) begin
      i_host.access(8'h08, 16, {16'h0, rows[i].mode}, rx);
      tick(4);
      `CHK("rate", rows[i].mode[3:0], rate_code)
      `CHK("buf_en", rows[i].mode[4], buf_en)
      `CHK("filter", rows[i].filt, filter_sel)
      i_host.access(8'h48, 16, 32'h0, rx);
      `CHK("mode", rows[i].mode, rx[15:0])
    end
    i_host.access(8'h10, 16, 32'h1234, rx);
    i_host.access(8'h50, 16, 32'h0, rx);
    `CHK("cfg", 16'h1234, rx[15:0])
    $display("done: mode table");
    push(24'ha5c3f0);
    wait_rdy();
    i_host.access(8'h40, 8, 32'h0, rx);
    `CHK("status", 8'h00, rx[7:0])
    i_host.access(8'h58, 24, 32'h0, rx);
    `CHK("data", 24'ha5c3f0, rx[23:0])
    tick(4);
    `CHK("rdy_n", 1'b1, rdy_n)
    i_host.access(8'h58, 24, 32'h0, rx);
    `CHK("reread", 24'ha5c3f0, rx[23:0])
    $display("done: data read");
    // Results arrive mid-read: they queue until the read ends, then drain.
    i_host.access(8'h58, 4, 32'h0, rx);
    k = 0;
    res_valid <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      if (res_ready === 1'b1) k++;
      res_data <= 24'h100000 + 24'(k);
    end
    res_valid <= 1'b0;
    `CHK("accepted", 16, k)
    i_host.xfer(20, 32'h0, rx);
    `CHK("held", 20'h5c3f0, rx[19:0])
    tick(40);
    `CHK("res_ready", 1'b1, res_ready)
    i_host.access(8'h58, 24, 32'h0, rx);
    `CHK("drained", 24'h10000f, rx[23:0])
    $display("done: fifo");
    i_host.xfer(8, 32'h5c, rx);
    push(24'h0badc0);
    wait_rdy();
    i_host.xfer(24, 32'h0, rx);
    `CHK("stream", 24'h0badc0, rx[23:0])
    push(24'h111111);
    tick(10);
    push(24'h222222);
    tick(10);
    i_host.xfer(24, 32'h0, rx);
    `CHK("newer", 24'h222222, rx[23:0])
    push(24'h333333);
    wait_rdy();
    i_host.xfer(8, 32'h58, rx);
    i_host.access(8'h48, 16, 32'h0, rx);
    `CHK("mode", 16'h000f, rx[15:0])
    $display("done: continuous read");
    i_host.access(8'h08, 16, 32'h201a, rx);
    tick(4);
    `CHK("mod_run", 1'b0, mod_run)
    for (k = 0; k < 200 && mod_run !== 1'b1; k++) @(posedge sys_clk);
    `CHK("osc", 1'b1, (k >= 12 && k <= 20))
    push(24'h444444);
    tick(10);
    `CHK("rdy_n", 1'b1, rdy_n)
    push(24'h555555);
    wait_rdy();
    tick(4);
    `CHK("mod_run", 1'b0, mod_run)
    i_host.access(8'h48, 16, 32'h0, rx);
    `CHK("mode", 16'h601a, rx[15:0])
    i_host.access(8'h58, 24, 32'h0, rx);
    `CHK("single", 24'h555555, rx[23:0])
    push(24'h666666);
    tick(10);
    `CHK("rdy_n", 1'b1, rdy_n)
    $display("done: single conversion");
    // The word ends in a zero, so the run below is exactly 32 ones.
    i_host.access(8'h08, 16, 32'h0002, rx);
    i_host.xfer(32, 32'hffffffff, rx);
    tick(12500);
    `CHK("rate", 4'ha, rate_code)
    `CHK("mod_run", 1'b1, mod_run)
    i_host.access(8'h48, 16, 32'h0, rx);
    `CHK("mode", 16'h001a, rx[15:0])
    i_host.access(8'h50, 16, 32'h0, rx);
    `CHK("cfg", 16'h0710, rx[15:0])
    $display("done: ones reset");
    stop_test();
  end
endmodule // test_sdac_ctrl
